//--- design/rc_pkg.sv
package rc_pkg;
    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_START   = 9'h002,
        ST_OPEN    = 9'h004,
        ST_DEAD    = 9'h008,
        ST_CLOSE   = 9'h010,
        ST_RECLAIM = 9'h020,
        ST_LOCKOUT = 9'h040,
        ST_GEN     = 9'h080,
        ST_LOCKED  = 9'h100
    } state_t;
    typedef enum logic [1:0] {
        RST_SIGNAL    = 2'h0,
        RST_OBJ_CLOSE = 2'h1,
        RST_CMD       = 2'h2
    } reset_mode_t;
endpackage

//--- design/reclose_unit.sv
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "recloser_params.svh"
// Summary of operation
// - disabled shots skipped, enabled use own settings
// - start-sourced request must persist start delay
// - start delay only for start-sourced requests
// - trip request with nonzero delay refused when idle
// - dead time counted from breaker open
// - arcing mode holds breaker closed
// - new request in arcing action locks
// - zero action time disables action phase
// - reclaim starts after reclose closes breaker
// - request during reclaim fails shot, advance
// - last shot failing issues final trip
// - request without enabled shots does nothing
// - not-ready reasons reported
// - inhibit on listed conditions
// - inhibit clears automatically to ready
// - lock on locking, final trip, object failures
// - request during general reclaim locks
// - request still held at dead end locks
// - critical request always locks
// - locked left only by reset paths
// - reset option: signal, close, command
// - lock-out time after success, request locks
// - manual close starts object close reclaim
// - reclose sequences start only when enabled
module reclose_unit #(
    parameter int unsigned FINE_TICK_CYC = `FINE_TICK_CYC
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [11:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic [4:0]  i_req_start,
    input  wire logic [4:0]  i_req_trip,
    input  wire logic        i_critical,
    input  wire logic        i_block,
    input  wire logic        i_on,
    input  wire logic        i_locking,
    input  wire logic        i_reset_lock,
    input  wire logic        i_any_close,
    input  wire logic        i_manual_close,
    input  wire logic        i_obj_open,
    input  wire logic        i_obj_closed,
    input  wire logic        i_obj_bad,
    input  wire logic        i_cmd_blocked,
    input  wire logic [3:0]  i_obj_fail,
    output logic             o_open_cmd,
    output logic             o_close_cmd,
    output logic             o_final_trip,
    output logic             o_ready,
    output logic             o_locked,
    output logic             o_running,
    output logic      [6:0]  o_inhibit_why,
    output logic      [8:0]  o_lock_why,
    output logic      [2:0]  o_shot
);
    // settings, all in 5 ms steps except reclaim in 0.5 ms steps
    logic [21:0]  cfg [`CFG_WORDS];
    logic [4:0]   ctrl;
    logic [18:0]  lockout_t;
    logic [18:0]  obj_recl_t;
    logic [24:0]  shot_en;
    logic [24:0]  shot_mode;
    // sequencer state
    rc_pkg::state_t st;
    logic [2:0]   cur_req;
    logic [2:0]   cur_shot;
    logic [21:0]  tmr;
    logic [21:0]  act;
    logic [4:0]   req_q;
    logic [14:0]  fine_cnt;
    logic         fine_tick;
    function automatic logic [2:0] first_set(input logic [4:0] v, input logic [2:0] from);
        logic [2:0] r;
        r = `SHOT_NONE;
        for (int i = 4; i >= 0; i--) begin
            if (v[i] && 3'(i) >= from) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction
    // state decode
    wire logic s_idle  = st == rc_pkg::ST_IDLE;
    wire logic s_start = st == rc_pkg::ST_START;
    wire logic s_dead  = st == rc_pkg::ST_DEAD;
    wire logic s_recl  = st == rc_pkg::ST_RECLAIM;
    wire logic s_lko   = st == rc_pkg::ST_LOCKOUT;
    wire logic s_gen   = st == rc_pkg::ST_GEN;
    wire logic s_lock  = st == rc_pkg::ST_LOCKED;
    // request edges; only one sequence owns the unit at a time
    wire logic [4:0] req_act  = i_req_start | i_req_trip;
    wire logic [4:0] req_rise = req_act & ~req_q;
    wire logic       any_rise = |req_rise;
    wire logic [2:0] pick_r   = first_set(req_rise, 3'h0);
    wire logic       cur_held = req_act[cur_req];
    // shot selection for the launch being considered
    wire logic [2:0] sel_req  = s_idle ? pick_r : cur_req;
    wire logic [2:0] req_c    = (sel_req > 3'h4) ? 3'h0 : sel_req;
    wire logic [4:0] row      = shot_en[5'(req_c) * 5'd5 +: 5];
    wire logic [2:0] pick_s   = first_set(row, 3'h0);
    wire logic [2:0] nxt_s    = first_set(row, 3'(cur_shot + 3'h1));
    wire logic [2:0] sel_shot = s_idle ? pick_s : (s_recl ? nxt_s : cur_shot);
    wire logic [2:0] shot_c   = (sel_shot > 3'h4) ? 3'h0 : sel_shot;
    wire logic [4:0] sel_idx  = 5'(5'(req_c) * 5'd5 + 5'(shot_c));
    wire logic [6:0] cfg_base = {sel_idx, 2'b00};
    wire logic [21:0] t_start = cfg[cfg_base];
    wire logic [21:0] t_dead  = cfg[7'(cfg_base + 7'h1)];
    wire logic [21:0] t_act   = cfg[7'(cfg_base + 7'h2)];
    wire logic [21:0] t_recl  = cfg[7'(cfg_base + 7'h3)];
    wire logic        disc    = shot_mode[sel_idx];
    wire logic        launch_trip = s_idle ? i_req_trip[pick_r] : i_req_trip[cur_req];
    // inhibit reasons; reported while not ready
    wire logic enabled = ctrl[`CTRL_EN] & i_on;
    wire logic [6:0] inh_now = {s_lock, s_gen, i_obj_bad, i_cmd_blocked,
                                s_lko, ~enabled, i_block};
    wire logic inhibit = |inh_now;
    // idle launch decisions
    wire logic try_go  = s_idle & any_rise & ~inhibit;
    wire logic no_shot = pick_s == `SHOT_NONE;
    wire logic refuse  = launch_trip & (t_start != 22'h0);
    // reclaim-phase outcomes on a new request, and a request still held at dead-time end
    wire logic arc_hold = s_recl & any_rise & (act != 22'h0) & ~disc;
    wire logic fin_trip = s_recl & any_rise & ~arc_hold & (nxt_s == `SHOT_NONE);
    wire logic dead_lk  = s_dead & (tmr == 22'h0) & cur_held;
    // lock reasons; any of them forces the locked state
    wire logic [8:0] lk_now = {i_critical, dead_lk, (s_gen | s_lko) & any_rise,
                               arc_hold, fin_trip, i_locking, 3'h0} | {5'h0, i_obj_fail};
    wire logic lock_set = |lk_now;
    // bus decode
    wire logic       bus_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire logic       bus_wr   = bus_req & i_wb_we & (i_wb_sel == 4'hf);
    wire logic [11:0] cfg_diff = i_wb_adr - `A_SHOT_BASE;
    wire logic [9:0] cfg_off  = cfg_diff[11:2]; // no wrap of high addresses onto cfg
    wire logic       cfg_hit  = (i_wb_adr >= `A_SHOT_BASE) & (cfg_off < 10'(`CFG_WORDS));
    wire logic       wr_ctrl  = bus_wr & (i_wb_adr == `A_CTRL);
    wire logic [31:0] status_w = {17'h0, cur_shot, cur_req, st};
    wire logic [31:0] reason_w = {16'h0, o_lock_why, o_inhibit_why};
    wire logic [31:0] rd_mux =
        cfg_hit                         ? {10'h0, cfg[7'(cfg_off)]} :
        (i_wb_adr == `A_CTRL)      ? {27'h0, ctrl}              :
        (i_wb_adr == `A_LOCKOUT)   ? {13'h0, lockout_t}         :
        (i_wb_adr == `A_OBJ_RECL)  ? {13'h0, obj_recl_t}        :
        (i_wb_adr == `A_SHOT_EN)   ? {7'h0, shot_en}            :
        (i_wb_adr == `A_SHOT_MODE) ? {7'h0, shot_mode}          :
        (i_wb_adr == `A_STATUS)    ? status_w                   :
        (i_wb_adr == `A_REASON)    ? reason_w                   : 32'h0;
    // unlock paths: reset input in every option, close and command per reset option; a new lock cause wins over release
    wire logic [1:0] rmode = ctrl[`CTRL_RMODE_LO +: 2];
    wire logic unlock = i_reset_lock
                      | (rmode == rc_pkg::RST_OBJ_CLOSE & i_any_close)
                      | (rmode == rc_pkg::RST_CMD & wr_ctrl & i_wb_dat[`CTRL_RST_CMD]);
    // bus slave: one-cycle registered ack, unmapped reads give zero
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else if (i_ce) begin
            o_wb_ack <= bus_req;
            o_wb_dat <= rd_mux;
        end
    end
    // setting storage; reset command bit is not stored
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl       <= 5'h0;
            lockout_t  <= 19'h0;
            obj_recl_t <= `OBJ_RECL_RST;
            shot_en    <= 25'h0;
            shot_mode  <= 25'h0;
            for (int i = 0; i < `CFG_WORDS; i++) begin
                cfg[i] <= 22'h0;
            end
        end else if (i_ce && bus_wr) begin
            if (cfg_hit) begin
                cfg[7'(cfg_off)] <= i_wb_dat[21:0];
            end
            case (i_wb_adr)
                `A_CTRL:      ctrl       <= {1'b0, i_wb_dat[3:0]};
                `A_LOCKOUT:   lockout_t  <= i_wb_dat[18:0];
                `A_OBJ_RECL:  obj_recl_t <= i_wb_dat[18:0];
                `A_SHOT_EN:   shot_en    <= i_wb_dat[24:0];
                `A_SHOT_MODE: shot_mode  <= i_wb_dat[24:0];
                default: ;
            endcase
        end
    end
    // 0.5 ms base tick; 5 ms settings are scaled by ten on load
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fine_cnt  <= 15'h0;
            fine_tick <= 1'b0;
        end else if (i_ce) begin
            fine_tick <= fine_cnt == 15'(FINE_TICK_CYC - 1);
            fine_cnt  <= (fine_cnt == 15'(FINE_TICK_CYC - 1)) ? 15'h0 : 15'(fine_cnt + 15'h1);
        end
    end
    // timer load values
    wire logic [21:0] ld_start = 22'(t_start * `FINE_PER_STEP);
    wire logic [21:0] ld_dead  = 22'(t_dead * `FINE_PER_STEP);
    wire logic [21:0] ld_act   = 22'(t_act * `FINE_PER_STEP);
    wire logic [21:0] ld_gen   = 22'({3'h0, obj_recl_t} * `FINE_PER_STEP);
    wire logic [21:0] ld_lko   = 22'({3'h0, lockout_t} * `FINE_PER_STEP);
    // sequencer; lock causes take priority over every other step
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st           <= rc_pkg::ST_IDLE;
            cur_req      <= 3'h0;
            cur_shot     <= 3'h0;
            tmr          <= 22'h0;
            act          <= 22'h0;
            req_q        <= 5'h0;
            o_open_cmd   <= 1'b0;
            o_close_cmd  <= 1'b0;
            o_final_trip <= 1'b0;
            o_lock_why   <= 9'h0;
        end else if (i_ce) begin
            req_q        <= req_act;
            o_open_cmd   <= 1'b0;
            o_close_cmd  <= 1'b0;
            o_final_trip <= fin_trip;
            if (fine_tick && tmr != 22'h0) begin
                tmr <= 22'(tmr - 22'h1);
            end
            if (fine_tick && act != 22'h0) begin
                act <= 22'(act - 22'h1);
            end
            if (lock_set && !s_lock) begin
                st         <= rc_pkg::ST_LOCKED;
                o_lock_why <= lk_now;
                o_open_cmd <= fin_trip | (s_lko & any_rise);
            end else begin
                case (st)
                    rc_pkg::ST_IDLE: begin
                        if (try_go && !no_shot && !refuse) begin
                            cur_req  <= pick_r;
                            cur_shot <= pick_s;
                            if (launch_trip) begin
                                o_open_cmd <= 1'b1;
                                st         <= rc_pkg::ST_OPEN;
                            end else begin
                                tmr <= ld_start;
                                st  <= rc_pkg::ST_START;
                            end
                        end else if (i_manual_close) begin
                            tmr <= ld_gen;
                            st  <= rc_pkg::ST_GEN;
                        end
                    end
                    rc_pkg::ST_START: begin
                        if (!cur_held) begin
                            st <= rc_pkg::ST_IDLE;
                        end else if (tmr == 22'h0) begin
                            o_open_cmd <= 1'b1;
                            st         <= rc_pkg::ST_OPEN;
                        end
                    end
                    rc_pkg::ST_OPEN: begin
                        if (i_obj_open) begin
                            tmr <= ld_dead;
                            st  <= rc_pkg::ST_DEAD;
                        end
                    end
                    rc_pkg::ST_DEAD: begin
                        if (tmr == 22'h0) begin
                            o_close_cmd <= 1'b1;
                            st          <= rc_pkg::ST_CLOSE;
                        end
                    end
                    rc_pkg::ST_CLOSE: begin
                        if (i_obj_closed) begin
                            tmr <= t_recl;
                            act <= ld_act;
                            st  <= rc_pkg::ST_RECLAIM;
                        end
                    end
                    rc_pkg::ST_RECLAIM: begin
                        if (any_rise) begin
                            cur_shot <= nxt_s;
                            if (launch_trip) begin
                                o_open_cmd <= 1'b1;
                                st         <= rc_pkg::ST_OPEN;
                            end else begin
                                tmr <= ld_start;
                                st  <= rc_pkg::ST_START;
                            end
                        end else if (tmr == 22'h0) begin
                            if (ctrl[`CTRL_GEN_RECL]) begin
                                tmr <= ld_gen;
                                st  <= rc_pkg::ST_GEN;
                            end else if (lockout_t != 19'h0) begin
                                tmr <= ld_lko;
                                st  <= rc_pkg::ST_LOCKOUT;
                            end else begin
                                st <= rc_pkg::ST_IDLE;
                            end
                        end
                    end
                    rc_pkg::ST_LOCKOUT, rc_pkg::ST_GEN: begin
                        if (tmr == 22'h0) begin
                            st <= rc_pkg::ST_IDLE;
                        end
                    end
                    rc_pkg::ST_LOCKED: begin
                        o_lock_why <= o_lock_why | lk_now;
                        if (unlock && !lock_set) begin
                            st         <= rc_pkg::ST_IDLE;
                            o_lock_why <= 9'h0;
                        end
                    end
                    default: st <= rc_pkg::ST_LOCKED;
                endcase
            end
        end
    end
    // status flags registered for outputs
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_inhibit_why <= 7'h0;
            o_ready       <= 1'b0;
            o_locked      <= 1'b0;
            o_running     <= 1'b0;
            o_shot        <= 3'h0;
        end else if (i_ce) begin
            o_inhibit_why <= inh_now;
            o_ready       <= ~inhibit;
            o_locked      <= s_lock;
            o_running     <= ~(s_idle | s_lock | s_gen | s_lko);
            o_shot        <= cur_shot;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst || !i_ce);
    property p_start_drop;
        s_start && !cur_held && !lock_set |=> s_idle && !o_open_cmd;
    endproperty
    a_start_drop: assert property (p_start_drop) else $error("released start kept going");
    property p_trip_refuse;
        try_go && refuse && !lock_set |=> st == rc_pkg::ST_IDLE || st == rc_pkg::ST_GEN;
    endproperty
    a_trip_refuse: assert property (p_trip_refuse) else $error("trip with delay launched");
    property p_no_shot;
        try_go && no_shot && !lock_set |=> !o_open_cmd ##1 !o_close_cmd;
    endproperty
    a_no_shot: assert property (p_no_shot) else $error("request with no shots acted");
    property p_dead_held;
        dead_lk |=> s_lock && o_lock_why[7] && !o_close_cmd;
    endproperty
    a_dead_held: assert property (p_dead_held) else $error("held request did not lock");
    property p_critical;
        i_critical |=> s_lock;
    endproperty
    a_critical: assert property (p_critical) else $error("critical request did not lock");
    property p_final;
        fin_trip && !s_lock |=> o_final_trip && o_open_cmd && s_lock;
    endproperty
    a_final: assert property (p_final) else $error("final trip missing");
    property p_arc;
        arc_hold |=> s_lock && !o_open_cmd;
    endproperty
    a_arc: assert property (p_arc) else $error("arcing request did not lock");
    property p_reclaim_load;
        $rose(s_recl) |-> tmr == $past(t_recl);
    endproperty
    a_reclaim_load: assert property (p_reclaim_load) else $error("reclaim not loaded");
    property p_ready;
        $fell(inhibit) |=> o_ready && o_inhibit_why == 7'h0;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not restored");
    property p_stay_locked;
        s_lock && (lock_set || !unlock) |=> s_lock;
    endproperty
    a_stay_locked: assert property (p_stay_locked) else $error("lock left without reset");
    c_success: cover property (s_recl ##1 s_idle);
    c_final: cover property (o_final_trip);
    c_unlock: cover property (s_lock ##1 s_idle);
endmodule // reclose_unit
`default_nettype wire

//--- design/recloser_params.svh
`ifndef RECLOSER_PARAMS_SVH
`define RECLOSER_PARAMS_SVH
// clock and timer base
`define CLK_PERIOD_NS   25
`define FINE_TICK_NS    500000
`define FINE_TICK_CYC   (`FINE_TICK_NS / `CLK_PERIOD_NS)
`define FINE_PER_STEP   22'h000a
// register byte offsets
`define A_CTRL          12'h000
`define A_LOCKOUT       12'h004
`define A_OBJ_RECL      12'h008
`define A_SHOT_EN       12'h00c
`define A_SHOT_MODE     12'h010
`define A_STATUS        12'h014
`define A_REASON        12'h018
`define A_SHOT_BASE     12'h200
`define CFG_WORDS       100
// control fields
`define CTRL_EN         0
`define CTRL_RMODE_LO   1
`define CTRL_GEN_RECL   3
`define CTRL_RST_CMD    4
// reset values
`define OBJ_RECL_RST    19'h0_07d0
`define SHOT_NONE       3'h5
`endif

//--- verification/obj_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// breaker object controller: latches one-cycle commands, moves after travel
module obj_ctrl_model #(
    parameter int TRAVEL = 5
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_open_cmd,
    input  wire logic i_close_cmd,
    output logic      o_obj_open,
    output logic      o_obj_closed
);
    int cnt;
    logic tgt_open;
    // both indications drop while the contacts travel, as a real breaker does
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt          <= 0;
            tgt_open     <= 1'b0;
            o_obj_open   <= 1'b0;
            o_obj_closed <= 1'b1;
        end else if (i_open_cmd || i_close_cmd) begin
            cnt          <= TRAVEL;
            tgt_open     <= i_open_cmd;
            o_obj_open   <= 1'b0;
            o_obj_closed <= 1'b0;
        end else if (cnt == 1) begin
            cnt          <= 0;
            o_obj_open   <= tgt_open;
            o_obj_closed <= !tgt_open;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // obj_ctrl_model
`default_nettype wire

//--- verification/test_reclose_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "recloser_params.svh"
module test_reclose_unit;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, rv;
    logic        ack, opc, clc, ftr, rdy, lkd, run, bo, bc;
    logic [4:0]  rq_st = 5'h00;
    logic [4:0]  rq_tr = 5'h00;
    logic [2:0]  inh_in = 3'h0;
    logic [1:0]  lk_in = 2'h0;
    logic        on = 1'b0;
    logic        rlk = 1'b0;
    logic        mcl = 1'b0;
    logic [6:0]  inh;
    logic [8:0]  lwhy;
    logic [2:0]  shot;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          n_open = 0;
    int          n_close = 0;
    int          n_final = 0;

    reclose_unit #(.FINE_TICK_CYC(4)) dut_u (
        .i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1),
        .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_req_start(rq_st), .i_req_trip(rq_tr), .i_critical(lk_in[1]),
        .i_block(inh_in[0]), .i_on(on), .i_locking(lk_in[0]),
        .i_reset_lock(rlk), .i_any_close(clc), .i_manual_close(mcl),
        .i_obj_open(bo), .i_obj_closed(bc), .i_obj_bad(inh_in[2]),
        .i_cmd_blocked(inh_in[1]), .i_obj_fail(4'h0), .o_open_cmd(opc),
        .o_close_cmd(clc), .o_final_trip(ftr), .o_ready(rdy), .o_locked(lkd),
        .o_running(run), .o_inhibit_why(inh), .o_lock_why(lwhy), .o_shot(shot)
    );
    obj_ctrl_model obj_u (
        .i_sys_clk(clk), .i_rst(rst), .i_open_cmd(opc), .i_close_cmd(clc),
        .o_obj_open(bo), .o_obj_closed(bc)
    );

    // clock, reset and one-cycle command pulse counters
    initial forever #12.5 clk = ~clk;
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    end
    always @(posedge clk) begin
        n_open  <= n_open + int'(opc);
        n_close <= n_close + int'(clc);
        n_final <= n_final + int'(ftr);
    end

    task automatic finish_test;
        $display("compares %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // classic cycle; request held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rv = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask

    task automatic shot_cfg(input int r, s, input logic [31:0] sd, dt, rc);
        logic [11:0] b;
        b = `A_SHOT_BASE + 12'(16 * (r * 5 + s));
        wb(1'b1, b, sd);
        wb(1'b1, b + 12'h004, dt);
        wb(1'b1, b + 12'h008, 32'h0000_0000);
        wb(1'b1, b + 12'h00c, rc);
    endtask

    // request line pulse; trip source unless st is set
    task automatic req(input int r, input bit st);
        if (st)
            rq_st[r] <= 1'b1;
        else
            rq_tr[r] <= 1'b1;
        repeat (3) @(posedge clk);
        rq_st <= 5'h00;
        rq_tr <= 5'h00;
        @(posedge clk);
    endtask

    // bounded wait on a command counter, a missing command shows as a miss
    task automatic wait_n(ref int cnt, input int target);
        int k;
        k = 0;
        while (cnt < target && k < 3000) begin
            @(posedge clk);
            k++;
        end
        check(32'(cnt), 32'(target));
    endtask

    task automatic unlock;
        rlk <= 1'b1;
        @(posedge clk);
        rlk <= 1'b0;
        repeat (3) @(posedge clk);
        check(lkd, 1'b0);
    endtask

    initial begin
        repeat (11) @(posedge clk);
        wb(1'b0, `A_OBJ_RECL, 32'h0000_0000);
        check(rv, 32'(`OBJ_RECL_RST));
        wb(1'b0, 12'h0f0, 32'h0000_0000);
        check(rv, 32'h0000_0000);
        check(rdy, 1'b0);
        on <= 1'b1;
        wb(1'b1, `A_CTRL, 32'h0000_0001);
        wb(1'b1, `A_SHOT_EN, 32'h0000_8443);
        wb(1'b0, `A_SHOT_EN, 32'h0000_0000);
        check(rv, 32'h0000_8443);
        shot_cfg(0, 0, 32'h0, 32'h1, 32'h14);
        shot_cfg(0, 1, 32'h0, 32'h1, 32'h14);
        shot_cfg(1, 1, 32'h0, 32'h1, 32'h14);
        shot_cfg(2, 0, 32'h2, 32'h1, 32'h14);
        shot_cfg(3, 0, 32'h1, 32'h1, 32'h14);
        check(rdy, 1'b1);
        // two-shot trip sequence, each reclaim interrupted by a new request
        req(0, 1'b0);
        check(32'(n_open), 32'h1);
        wait_n(n_close, 1);
        repeat (10) @(posedge clk);
        req(0, 1'b0);
        wait_n(n_open, 2);
        check(shot, 3'h1);
        wait_n(n_close, 2);
        repeat (10) @(posedge clk);
        req(0, 1'b0);
        wait_n(n_final, 1);
        repeat (3) @(posedge clk);
        check(lkd, 1'b1);
        check(lwhy[4], 1'b1);
        check({rdy, inh[6]}, 2'b01);
        unlock();
        // start-sourced request held across the whole dead time
        rq_st[2] <= 1'b1;
        repeat (60) @(posedge clk);
        check(32'(n_open), 32'h3);
        wait_n(n_open, 4);
        repeat (80) @(posedge clk);
        check(lwhy[7], 1'b1);
        rq_st <= 5'h00;
        unlock();
        // refused: trip with start delay, and a request with no shots
        req(3, 1'b0);
        req(4, 1'b0);
        repeat (20) @(posedge clk);
        check(32'(n_open), 32'h4);
        // first shot disabled, second one runs to a clean finish
        req(1, 1'b0);
        wait_n(n_open, 5);
        check(shot, 3'h1);
        repeat (30) @(posedge clk);
        check(32'(n_close), 32'h2);
        wait_n(n_close, 3);
        repeat (150) @(posedge clk);
        check({run, rdy}, 2'b01);
        // arcing action on shot 1 of request 1: a request inside it locks, no reopen
        wb(1'b1, 12'h268, 32'h0000_0001);
        req(1, 1'b0);
        wait_n(n_close, 4);
        repeat (10) @(posedge clk);
        req(1, 1'b0);
        check({lkd, lwhy[5]}, 2'b11);
        check(32'(n_open), 32'h6);
        unlock();
        // block, command-blocked and object-bad inhibits each alone: reason bit and automatic return
        for (int i = 0; i < 3; i++) begin
            inh_in[i] <= 1'b1;
            repeat (3) @(posedge clk);
            check({rdy, inh}, {1'b0, 7'(1) << (i == 0 ? 0 : i + 2)});
            inh_in[i] <= 1'b0;
            repeat (3) @(posedge clk);
            check(rdy, 1'b1);
        end
        // locking input, then critical request; lock stays after release
        for (int i = 0; i < 2; i++) begin
            lk_in[i] <= 1'b1;
            repeat (3) @(posedge clk);
            lk_in[i] <= 1'b0;
            repeat (10) @(posedge clk);
            check({lkd, lwhy}, {1'b1, 9'(1) << (i == 0 ? 3 : 8)});
            unlock();
        end
        // manual close runs object close reclaim; a request inside it locks
        wb(1'b1, `A_OBJ_RECL, 32'h0000_0002);
        mcl <= 1'b1;
        @(posedge clk);
        mcl <= 1'b0;
        repeat (3) @(posedge clk);
        check({rdy, inh[5]}, 2'b01);
        req(0, 1'b0);
        check({lkd, lwhy[6]}, 2'b11);
        // command reset mode: selecting it alone keeps the lock, the write-one bit frees it
        wb(1'b1, `A_CTRL, 32'h0000_0005);
        check(lkd, 1'b1);
        wb(1'b1, `A_CTRL, 32'h0000_0015);
        repeat (2) @(posedge clk);
        check(lkd, 1'b0);
        wb(1'b0, `A_CTRL, 32'h0000_0000);
        check(rv, 32'h0000_0005);
        finish_test();
    end

    // hang guard, well beyond the fewer than a thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule // test_reclose_unit
`default_nettype wire
